// *** cct_timer16.sv ***
// 16-bit capture/compare timer with AXI4-Lite registers
// ----------------------------------------------------------------
// Overview of operation
// - Read-only 16-bit counter advances once per selected count tick.
// - A count read freezes the count tick for that cycle.
// - Counter is zero after reset and while both run bits are zero.
// - Mode clear-on-A-edge zeroes counter on each valid input A edge.
// - Mode clear-on-match zeroes counter when it equals register A in compare use.
// - One-shot mode zeroes counter on soft trigger or valid A edge.
// - Control bit 0 picks capture or compare use of register A.
// - Compare A raises match A pulse whenever counter reaches it.
// - Capture A triggers from input A or input B edge.
// - A edge codes: 00 fall, 01 rise, 11 both; A capture opposite edge, none for 11.
// - B edge codes: 00 fall, 01 rise, 11 both; capture same edge.
// - Compare registers read/write 16 bits; capture registers ignore writes.
// - Reset loads register A with zero.
// - Register A zero matches after the counter wraps past FFFF.
// - Control bit 2 picks capture or compare use of register B.
// - Compare B raises match B pulse whenever counter reaches it.
// - Capture B happens on the valid input A edge.
// - Output pin is timer output ORed with the port latch.
// - Input A serves as filtered external event count source.
// - Counter stays stopped while both run bits are zero.
// - Wrap from FFFF to 0000 sets the overflow flag.
// ----------------------------------------------------------------
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
module cct_timer16 (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // AXI4-Lite write
    input  wire logic [5:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [5:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Timer pins
    input  wire logic        trigger_input_a,
    input  wire logic        trigger_input_b,
    output logic             timer_output_pin,
    output logic             match_irq_a,
    output logic             match_irq_b
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic es_hit(input logic [1:0] es,
                                    input logic rise,
                                    input logic fall);
        case (es)
            cct_pkg::ES_FALL: es_hit = fall;
            cct_pkg::ES_RISE: es_hit = rise;
            cct_pkg::ES_BOTH: es_hit = rise | fall;
            default:          es_hit = 1'b0;
        endcase
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] st);
        merge16 = {st[1] ? wd[15:8] : old[15:8],
                   st[0] ? wd[7:0] : old[7:0]};
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [2:0]  mode_r;
    logic        ovf_r;
    logic [2:0]  ccctl_r;
    logic [5:0]  presc_r;
    logic [1:0]  outctl_r;
    logic        os_trig_r;
    logic [1:0]  port_r;
    logic [15:0] count_r;
    logic [15:0] cc_a_r;
    logic [15:0] cc_b_r;
    logic [3:0]  pre_r;
    logic [1:0]  filt_r;
    logic [1:0]  prev_r;
    logic [1:0]  fcnt_r [2];
    logic        tout_r;
    logic [5:0]  awaddr_r;
    logic        aw_full_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        w_full_r;

    // ------------------------------------------------------------
    // Edge decode
    // ------------------------------------------------------------
    wire logic [1:0] es_a     = presc_r[cct_pkg::ES_A_LO +: 2];
    wire logic [1:0] es_b     = presc_r[cct_pkg::ES_B_LO +: 2];
    wire logic [1:0] csel     = presc_r[cct_pkg::CSEL_LO +: 2];
    wire logic [1:0] rise     = filt_r & ~prev_r;
    wire logic [1:0] fall     = ~filt_r & prev_r;
    wire logic       valid_a  = es_hit(es_a, rise[0], fall[0]);
    wire logic       valid_b  = es_hit(es_b, rise[1], fall[1]);
    wire logic [1:0] cap_es_a = (es_a == cct_pkg::ES_BOTH) ?
                                cct_pkg::ES_NONE :
                                {1'b0, ~es_a[0]};
    wire logic       cap_a_pin = es_hit(cap_es_a, rise[0], fall[0]);
    wire logic       cap_a    = ccctl_r[cct_pkg::CC_A_CAP_BIT];
    wire logic       cap_b    = ccctl_r[cct_pkg::CC_B_CAP_BIT];
    wire logic       cap_a_evt = cap_a &
                                 (ccctl_r[cct_pkg::CC_A_SRC_BIT] ?
                                  valid_b : cap_a_pin);
    wire logic       cap_b_evt = cap_b & valid_a;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic ar_take = s_axi_arvalid & s_axi_arready;
    wire logic aw_take = s_axi_awvalid & s_axi_awready;
    wire logic w_take  = s_axi_wvalid & s_axi_wready;
    wire logic wr_do   = aw_full_r & w_full_r & ~s_axi_bvalid;
    wire logic wr_mode = wr_do & (awaddr_r == cct_pkg::OFF_MODE);
    wire logic wr_cc   = wr_do & (awaddr_r == cct_pkg::OFF_CCCTL);
    wire logic wr_pre  = wr_do & (awaddr_r == cct_pkg::OFF_PRESC);
    wire logic wr_out  = wr_do & (awaddr_r == cct_pkg::OFF_OUTCTL);
    wire logic wr_port = wr_do & (awaddr_r == cct_pkg::OFF_PORT);
    wire logic wr_cca  = wr_do & (awaddr_r == cct_pkg::OFF_CCA);
    wire logic wr_ccb  = wr_do & (awaddr_r == cct_pkg::OFF_CCB);
    wire logic wr_cnt  = wr_do & (awaddr_r == cct_pkg::OFF_COUNT);
    wire logic wr_ok   = wr_mode | wr_cc | wr_pre | wr_out | wr_port |
                         wr_cca | wr_ccb | wr_cnt;
    wire logic wr_b0   = wstrb_r[0];
    wire logic freeze  = ar_take &
                         (s_axi_araddr == cct_pkg::OFF_COUNT);

    // ------------------------------------------------------------
    // Count control
    // ------------------------------------------------------------
    wire logic [1:0] run_mode = mode_r[2:1];
    wire logic run = (run_mode != cct_pkg::RUN_STOP);
    wire logic os_mode = outctl_r[1];
    wire logic cnt_en = (csel == cct_pkg::CSEL_DIV1) ||
                        (csel == cct_pkg::CSEL_DIV4 &&
                         pre_r[1:0] == 2'h3) ||
                        (csel == cct_pkg::CSEL_D16 &&
                         pre_r == 4'hf) ||
                        (csel == cct_pkg::CSEL_EXT && valid_a);
    wire logic tick = run & cnt_en & ~freeze;
    wire logic [15:0] count_inc = count_r + 16'h0001;
    wire logic clr_ext = run & (run_mode == cct_pkg::RUN_CLR_A) &
                         valid_a;
    wire logic clr_os = run & os_mode & (os_trig_r | valid_a);
    wire logic clr_match = tick & (run_mode == cct_pkg::RUN_CLR_M) &
                           ~cap_a & (count_r == cc_a_r);
    wire logic clr_any = clr_ext | clr_os | clr_match;
    wire logic cmp_a = tick & ~clr_ext & ~clr_os & ~cap_a &
                       ~clr_match & (count_inc == cc_a_r);
    wire logic cmp_b = tick & ~clr_ext & ~clr_os & ~cap_b &
                       ~clr_match & (count_inc == cc_b_r);
    wire logic ovf_set = tick & ~clr_ext & ~clr_os &
                         (count_r == cct_pkg::CNT_MAX);
    wire logic [15:0] count_nxt = !run ? cct_pkg::CNT_RST :
                                  clr_any ? cct_pkg::CNT_RST :
                                  tick ? count_inc : count_r;
    wire logic pin_src = tout_r | port_r[cct_pkg::LATCH_BIT];

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    wire logic rd_ok = (s_axi_araddr[1:0] == 2'h0) &&
                       (s_axi_araddr <= cct_pkg::OFF_PORT);
    logic [15:0] rd_mux;
    always_comb begin
        case (s_axi_araddr)
            cct_pkg::OFF_MODE:   rd_mux = {12'h000, mode_r, ovf_r};
            cct_pkg::OFF_CCCTL:  rd_mux = {13'h0000, ccctl_r};
            cct_pkg::OFF_PRESC:  rd_mux = {10'h000, presc_r};
            cct_pkg::OFF_OUTCTL: rd_mux = {10'h000, outctl_r[1],
                                           4'h0, outctl_r[0]};
            cct_pkg::OFF_COUNT:  rd_mux = count_r;
            cct_pkg::OFF_CCA:    rd_mux = cc_a_r;
            cct_pkg::OFF_CCB:    rd_mux = cc_b_r;
            cct_pkg::OFF_PORT:   rd_mux = {14'h0000, port_r};
            default:             rd_mux = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // AXI4-Lite handshakes
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_full_r     <= 1'b0;
            w_full_r      <= 1'b0;
            awaddr_r      <= 6'h00;
            wdata_r       <= 32'h00000000;
            wstrb_r       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= cct_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                awaddr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            aw_full_r     <= (aw_full_r | aw_take) & ~wr_do;
            w_full_r      <= (w_full_r | w_take) & ~wr_do;
            s_axi_awready <= ~((aw_full_r | aw_take) & ~wr_do);
            s_axi_wready  <= ~((w_full_r | w_take) & ~wr_do);
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? cct_pkg::RESP_OKAY :
                                        cct_pkg::RESP_SLV;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= cct_pkg::RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_ok ? {16'h0000, rd_mux} : 32'h00000000;
            s_axi_rresp   <= rd_ok ? cct_pkg::RESP_OKAY :
                                     cct_pkg::RESP_SLV;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end else begin
            s_axi_arready <= ~s_axi_rvalid;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r    <= cct_pkg::CTL_RST[3:1];
            ovf_r     <= 1'b0;
            ccctl_r   <= cct_pkg::CTL_RST[2:0];
            presc_r   <= cct_pkg::CTL_RST[5:0];
            outctl_r  <= cct_pkg::CTL_RST[1:0];
            os_trig_r <= 1'b0;
            port_r    <= cct_pkg::CTL_RST[1:0];
        end else begin
            if (wr_mode && wr_b0) begin
                mode_r <= wdata_r[cct_pkg::MODE_LO +: 3];
            end
            if (ovf_set) begin
                ovf_r <= 1'b1;
            end else if (wr_mode && wr_b0 &&
                         !wdata_r[cct_pkg::MODE_OVF_BIT]) begin
                ovf_r <= 1'b0;
            end
            if (wr_cc && wr_b0) begin
                ccctl_r <= wdata_r[2:0];
            end
            if (wr_pre && wr_b0) begin
                presc_r <= wdata_r[5:0];
            end
            if (wr_out && wr_b0) begin
                outctl_r <= {wdata_r[cct_pkg::OS_EN_BIT],
                             wdata_r[cct_pkg::OUT_EN_BIT]};
            end
            os_trig_r <= wr_out & wr_b0 &
                         wdata_r[cct_pkg::OS_TRIG_BIT];
            if (wr_port && wr_b0) begin
                port_r <= {wdata_r[cct_pkg::DIR_BIT],
                           wdata_r[cct_pkg::LATCH_BIT]};
            end
        end
    end

    // ------------------------------------------------------------
    // Input filter and prescaler
    // ------------------------------------------------------------
    wire logic [1:0] pins = {trigger_input_b, trigger_input_a};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filt_r <= 2'h0;
            prev_r <= 2'h0;
            pre_r  <= 4'h0;
            for (int i = 0; i < 2; i++) begin
                fcnt_r[i] <= 2'h0;
            end
        end else begin
            prev_r <= filt_r;
            pre_r  <= pre_r + 4'h1;
            for (int i = 0; i < 2; i++) begin
                if (pins[i] == filt_r[i]) begin
                    fcnt_r[i] <= 2'h0;
                end else if (fcnt_r[i] == cct_pkg::FILT_CYC - 2'h1) begin
                    fcnt_r[i] <= 2'h0;
                    filt_r[i] <= pins[i];
                end else begin
                    fcnt_r[i] <= fcnt_r[i] + 2'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Counter, capture/compare, outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r          <= cct_pkg::CNT_RST;
            cc_a_r           <= cct_pkg::CC_RST;
            cc_b_r           <= cct_pkg::CC_RST;
            tout_r           <= 1'b0;
            timer_output_pin <= 1'b0;
            match_irq_a      <= 1'b0;
            match_irq_b      <= 1'b0;
        end else begin
            count_r <= count_nxt;
            if (cap_a_evt) begin
                cc_a_r <= count_r;
            end else if (wr_cca && !cap_a) begin
                cc_a_r <= merge16(cc_a_r, wdata_r, wstrb_r);
            end
            if (cap_b_evt) begin
                cc_b_r <= count_r;
            end else if (wr_ccb && !cap_b) begin
                cc_b_r <= merge16(cc_b_r, wdata_r, wstrb_r);
            end
            if (cmp_a && outctl_r[0]) begin
                tout_r <= ~tout_r;
            end
            timer_output_pin <= pin_src;
            match_irq_a      <= cmp_a | cap_a_evt;
            match_irq_b      <= cmp_b | cap_b_evt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_stop_holds_zero: assert property (@(posedge clk)
        disable iff (!rst_n) !run |=> count_r == 16'h0000)
        else $error("counter not zero while stopped");
    a_count_step: assert property (@(posedge clk)
        disable iff (!rst_n) tick && !clr_any |=>
        count_r == $past(count_inc))
        else $error("counter did not advance by one");
    a_read_freeze: assert property (@(posedge clk)
        disable iff (!rst_n) freeze && run && !clr_any |=>
        count_r == $past(count_r) && s_axi_rdata[15:0] == count_r)
        else $error("count moved during read");
    a_ext_clear: assert property (@(posedge clk)
        disable iff (!rst_n) clr_ext |=> count_r == 16'h0000)
        else $error("edge clear missed");
    a_match_clear: assert property (@(posedge clk)
        disable iff (!rst_n) clr_match |=> count_r == 16'h0000)
        else $error("match clear missed");
    a_oneshot_clear: assert property (@(posedge clk)
        disable iff (!rst_n) clr_os |=> count_r == 16'h0000)
        else $error("one-shot clear missed");
    a_match_a_irq: assert property (@(posedge clk)
        disable iff (!rst_n) cmp_a |=> match_irq_a &&
        count_r == $past(cc_a_r))
        else $error("match A pulse missing");
    a_capture_a_copy: assert property (@(posedge clk)
        disable iff (!rst_n) cap_a_evt |=> cc_a_r == $past(count_r))
        else $error("capture A wrong value");
    a_capture_b_copy: assert property (@(posedge clk)
        disable iff (!rst_n) cap_b_evt |=> cc_b_r == $past(count_r))
        else $error("capture B wrong value");
    a_cap_write_ignored: assert property (@(posedge clk)
        disable iff (!rst_n) cap_a && !cap_a_evt |=>
        cc_a_r == $past(cc_a_r))
        else $error("capture register was written");
    a_pin_or: assert property (@(posedge clk)
        disable iff (!rst_n) 1'b1 |=> timer_output_pin == $past(pin_src))
        else $error("output pin is not the OR");
    a_ovf_flag: assert property (@(posedge clk)
        disable iff (!rst_n) ovf_set |=> ovf_r && count_r == 16'h0000)
        else $error("overflow flag not set");
endmodule // cct_timer16

// *** cct_pkg.sv ***
// Constants for the 16-bit capture/compare timer
package cct_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [5:0] OFF_MODE   = 6'h00;
    localparam logic [5:0] OFF_CCCTL  = 6'h04;
    localparam logic [5:0] OFF_PRESC  = 6'h08;
    localparam logic [5:0] OFF_OUTCTL = 6'h0c;
    localparam logic [5:0] OFF_COUNT  = 6'h10;
    localparam logic [5:0] OFF_CCA    = 6'h14;
    localparam logic [5:0] OFF_CCB    = 6'h18;
    localparam logic [5:0] OFF_PORT   = 6'h1c;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MODE_OVF_BIT = 0;
    localparam int MODE_LO      = 1;
    localparam int CC_A_CAP_BIT = 0;
    localparam int CC_A_SRC_BIT = 1;
    localparam int CC_B_CAP_BIT = 2;
    localparam int ES_A_LO      = 0;
    localparam int ES_B_LO      = 2;
    localparam int CSEL_LO      = 4;
    localparam int OUT_EN_BIT   = 0;
    localparam int OS_EN_BIT    = 5;
    localparam int OS_TRIG_BIT  = 6;
    localparam int LATCH_BIT    = 0;
    localparam int DIR_BIT      = 1;
    // ------------------------------------------------------------
    // Encodings and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] RUN_STOP  = 2'h0;
    localparam logic [1:0] RUN_FREE  = 2'h1;
    localparam logic [1:0] RUN_CLR_A = 2'h2;
    localparam logic [1:0] RUN_CLR_M = 2'h3;
    localparam logic [1:0] ES_FALL   = 2'h0;
    localparam logic [1:0] ES_RISE   = 2'h1;
    localparam logic [1:0] ES_NONE   = 2'h2;
    localparam logic [1:0] ES_BOTH   = 2'h3;
    localparam logic [1:0] CSEL_DIV1 = 2'h0;
    localparam logic [1:0] CSEL_DIV4 = 2'h1;
    localparam logic [1:0] CSEL_D16  = 2'h2;
    localparam logic [1:0] CSEL_EXT  = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLV  = 2'h2;
    localparam logic [15:0] CNT_RST  = 16'h0000;
    localparam logic [15:0] CNT_MAX  = 16'hffff;
    localparam logic [15:0] CC_RST   = 16'h0000;
    localparam logic [7:0]  CTL_RST  = 8'h00;
    localparam logic [1:0]  FILT_CYC = 2'h3;
endpackage

// *** cct_trig_model.sv ***
// Model of the external trigger pins
module cct_trig_model (
    // Clock
    input  wire logic clk,
    // Trigger pins
    output logic      trig_a,
    output logic      trig_b
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        trig_a = 1'b0;
        trig_b = 1'b0;
    end
    // New levels held long enough for the noise filter
    task automatic drive(input logic a, input logic b);
        @(posedge clk);
        trig_a <= a;
        trig_b <= b;
        repeat (10) @(posedge clk);
    endtask
endmodule // cct_trig_model

// *** cct_timer16_tb.sv ***
// Self-checking testbench of the capture/compare timer
module cct_timer16_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, awv, wv, arv, awr, wrd, bv, arr, rv;
    logic        tpin, ia, ib, ta, tb;
    logic [5:0]  awa, ara;
    logic [31:0] wd, rdat, r;
    logic [1:0]  br, rr;
    logic [33:0] exp_q[$];
    int          err_count = 0;
    int          checks = 0;
    int          na = 0;
    int          n;
    integer      seed = 32'h4b82b5b6;
    // ------------------------------------------------------------
    // Design and trigger model
    // ------------------------------------------------------------
    cct_timer16 DUT (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(1'b1), .trigger_input_a(ta), .trigger_input_b(tb),
        .timer_output_pin(tpin), .match_irq_a(ia), .match_irq_b(ib));
    cct_trig_model PM (.clk(clk), .trig_a(ta), .trig_b(tb));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [33:0] got, input logic [33:0] e);
        checks++;
        if (got !== e) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, e);
        end
    endtask
    task automatic summarize;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        awa <= a;
        wd  <= d;
        awv <= 1'b1;
        wv  <= 1'b1;
        do begin
            @(posedge clk);
            if (awr === 1'b1) awv <= 1'b0;
            if (wrd === 1'b1) wv <= 1'b0;
        end while (bv !== 1'b1);
        chk(br, cct_pkg::RESP_OKAY);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        exp_q.push_back({((a > cct_pkg::OFF_PORT) ? cct_pkg::RESP_SLV :
                          cct_pkg::RESP_OKAY), e});
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        while (rv !== 1'b1) @(posedge clk);
    endtask
    task automatic gap(input bit b, output int g);
        int k;
        k = 0;
        do begin @(posedge clk); k++; end
        while ((b ? ib : ia) !== 1'b1 && k < 300);
        g = 0;
        do begin @(posedge clk); g++; end
        while ((b ? ib : ia) !== 1'b1 && g < 300);
    endtask
    // ------------------------------------------------------------
    // Clock, monitors and watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (ia === 1'b1) na <= na + 1;
        if (rst_n && rv === 1'b1 && exp_q.size() > 0)
            chk({rr, rdat}, exp_q.pop_front());
    end
    initial begin
        repeat (80000) @(posedge clk);
        err_count++;
        summarize;
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        {awv, wv, arv} = 3'h0;
        {awa, ara, wd} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rd(cct_pkg::OFF_COUNT, 32'h0);
        rd(cct_pkg::OFF_CCA, 32'h0);
        rd(6'h20, 32'h0);
        wr(cct_pkg::OFF_COUNT, 32'h55);
        rd(cct_pkg::OFF_COUNT, 32'h0);
        r = $random(seed);
        r = {16'h0, r[15:1], 1'b1};
        wr(cct_pkg::OFF_CCA, r);
        rd(cct_pkg::OFF_CCA, r);
        wr(cct_pkg::OFF_CCCTL, 32'h3);
        wr(cct_pkg::OFF_PRESC, 32'h4);
        wr(cct_pkg::OFF_CCA, ~r);
        rd(cct_pkg::OFF_CCA, r);
        n = na;
        PM.drive(1'b0, 1'b1);
        chk(na - n, 32'h1);
        rd(cct_pkg::OFF_CCA, 32'h0);
        wr(cct_pkg::OFF_CCCTL, 32'h0);
        wr(cct_pkg::OFF_CCA, 32'h9);
        wr(cct_pkg::OFF_CCB, 32'h5);
        wr(cct_pkg::OFF_MODE, 32'hc);
        gap(1'b0, n);
        chk(n, 32'ha);
        gap(1'b1, n);
        chk(n, 32'ha);
        wr(cct_pkg::OFF_PRESC, 32'h14);
        gap(1'b0, n);
        chk(n, 32'h28);
        wr(cct_pkg::OFF_PRESC, 32'h24);
        gap(1'b0, n);
        chk(n, 32'ha0);
        wr(cct_pkg::OFF_MODE, 32'h0);
        rd(cct_pkg::OFF_COUNT, 32'h0);
        wr(cct_pkg::OFF_PORT, 32'h1);
        repeat (3) @(posedge clk);
        chk({31'h0, tpin}, 32'h1);
        wr(cct_pkg::OFF_PORT, 32'h0);
        repeat (3) @(posedge clk);
        chk({31'h0, tpin}, 32'h0);
        wr(cct_pkg::OFF_PRESC, 32'h31);
        wr(cct_pkg::OFF_MODE, 32'h4);
        PM.drive(1'b1, 1'b1);
        PM.drive(1'b0, 1'b1);
        PM.drive(1'b1, 1'b1);
        rd(cct_pkg::OFF_COUNT, 32'h2);
        wr(cct_pkg::OFF_OUTCTL, 32'h60);
        rd(cct_pkg::OFF_COUNT, 32'h0);
        wr(cct_pkg::OFF_OUTCTL, 32'h0);
        PM.drive(1'b0, 1'b1);
        PM.drive(1'b1, 1'b1);
        wr(cct_pkg::OFF_CCCTL, 32'h5);
        wr(cct_pkg::OFF_MODE, 32'h8);
        PM.drive(1'b0, 1'b1);
        rd(cct_pkg::OFF_CCA, 32'h1);
        PM.drive(1'b1, 1'b1);
        rd(cct_pkg::OFF_CCB, 32'h1);
        rd(cct_pkg::OFF_COUNT, 32'h0);
        wr(cct_pkg::OFF_MODE, 32'h0);
        wr(cct_pkg::OFF_PRESC, 32'h0);
        wr(cct_pkg::OFF_CCCTL, 32'h0);
        wr(cct_pkg::OFF_CCA, 32'hffff);
        n = na;
        wr(cct_pkg::OFF_MODE, 32'hc);
        repeat (65600) @(posedge clk);
        chk(na - n, 32'h1);
        rd(cct_pkg::OFF_MODE, 32'hd);
        summarize;
    end
endmodule // cct_timer16_tb
